//--- verilog/cmd_reg_defines.svh
// Register offsets, command bit positions, reset values and field layouts.
`ifndef CMD_REG_DEFINES_SVH
`define CMD_REG_DEFINES_SVH

`define OFS_COMMAND 6'h00
`define OFS_DATA_CONFIG 6'h01
`define OFS_INT_MASK 6'h04
`define OFS_TX_PACKET_SIZE 6'h08
`define OFS_TX_FRAG_COUNT 6'h09
`define OFS_TX_START_LOW 6'h0a
`define OFS_TX_START_HIGH 6'h0b
`define OFS_TX_FRAG_SIZE 6'h0c
`define OFS_RX_BUF_LOW 6'h0f
`define OFS_RX_BUF_HIGH 6'h10
`define OFS_RX_WORDS_LOW 6'h11
`define OFS_RX_WORDS_HIGH 6'h12
`define OFS_RES_READ_PTR 6'h17
`define OFS_TEMP_RX_LOW 6'h19
`define OFS_TEMP_RX_HIGH 6'h1a
`define OFS_TEMP_WORDS_LOW 6'h1b
`define OFS_TEMP_WORDS_HIGH 6'h1c
`define OFS_ADDR_GEN_LOW 6'h1d
`define OFS_ADDR_GEN_HIGH 6'h1e
`define OFS_LAST_LINK 6'h1f
`define OFS_TEMP_TX_DESC 6'h20
`define OFS_MATCH_PORT_TWO 6'h22
`define OFS_MATCH_PORT_ONE 6'h23
`define OFS_MATCH_PORT_ZERO 6'h24
`define OFS_MATCH_ENABLE 6'h25
`define OFS_MATCH_DESC_PTR 6'h26
`define OFS_SILICON_REV 6'h28
`define OFS_WATCHDOG_LOW 6'h29
`define OFS_WATCHDOG_HIGH 6'h2a
`define OFS_CRC_TALLY 6'h2c
`define OFS_ALIGN_TALLY 6'h2d
`define OFS_MISSED_TALLY 6'h2e
`define OFS_MAX_DEFERRAL 6'h2f
`define OFS_TEST_FIRST 6'h30
`define OFS_TEST_LAST 6'h3e
`define OFS_DATA_CONFIG_TWO 6'h3f

`define BIT_LOAD_MATCH 9
`define BIT_READ_RES 8
`define BIT_SOFT_RESET 7
`define BIT_TIMER_START 5
`define BIT_TIMER_STOP 4
`define BIT_RX_ON 3
`define BIT_RX_OFF 2
`define BIT_TX_GO 1
`define BIT_TX_HALT 0
`define CMD_WRITABLE_MASK 16'h03bf
`define CMD_HW_RESET 16'h0094
`define CMD_SW_CLEAR_MASK 16'h0303
`define CMD_SW_SET_MASK 16'h0084

`define DCFG_WIDTH_BIT 5
`define DCFG_HW_CLEAR_MASK 16'h5fff
`define INT_MASK_TIMER_BIT 0
`define SILICON_REV_VALUE 16'h0001

`endif

//--- verilog/cmd_reg_pkg.sv
// Types shared by the command register block.
package cmd_reg_pkg;
  typedef enum logic [1:0] {
    CMD_IDLE = 2'b00,
    CMD_LOAD_MATCH = 2'b01,
    CMD_READ_RES = 2'b10
  } cmd_state_t;
endpackage : cmd_reg_pkg

//--- verilog/command_register_control.sv
// Register bank with command register, reset-mode gating and watchdog timer.
`timescale 1ns/1ps
`default_nettype none
`include "cmd_reg_defines.svh"

// Functional notes
// - Match read ports valid only during soft reset.
// - Match enable writable by host only in reset.
// - Data config writes ignored unless soft reset.
// - Tally counters store complement of written data.
// - Packet size reads return written complement.
// - Fragment size shifted one or two by width.
// - Command bits 9, 8 self-clear after command completes.
// - Writing zero to command bits does nothing, except bit 7 clears soft reset.
// - Watchdog decrements when started, interrupt at zero.
// - Hardware reset sets bits 7, 4, 2.
// - Soft reset clears 9,8,1,0, sets 7,2.
// - Bit 9 loads match table from pointer.
// - Bit 8 fetches resource descriptor at pointer.
// - Soft reset holds engines, freezes tallies.
// - Operational only after soft reset cleared.
// - Start bit runs timer, clears stop bit.
// - Stop bit halts timer, clears start bit.
// - Start with stop together means stop.
// - Chip select plus six lines choose register.
module command_register_control (
  // Clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Host register port
  input wire logic chipSelect,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  input wire logic [5:0] registerSelectLines,
  input wire logic [15:0] writeData,
  output logic [15:0] readData,
  // Command execution handshake with the engines, error events and status outputs
  input wire logic matchLoadDone,
  input wire logic resourceReadDone,
  input wire logic [15:0] matchEnableLoad,
  input wire logic [47:0] matchEntryData,
  input wire logic crcErrorEvent,
  input wire logic alignErrorEvent,
  input wire logic missedPacketEvent,
  output logic loadMatchRequest,
  output logic readResourceRequest,
  output logic [15:0] descPointer,
  output logic enginesHeld,
  output logic timerInterrupt
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [15:0] commandBits;
  logic [15:0] dataConfig;
  logic [15:0] dataConfigTwo;
  logic [15:0] intMask;
  logic [15:0] matchEnable;
  logic [15:0] matchDescPointer;
  logic [15:0] resourceReadPointer;
  logic [15:0] crcTally;
  logic [15:0] alignTally;
  logic [15:0] missedTally;
  logic [15:0] txPacketSize;
  logic [15:0] txFragmentSize;
  logic [31:0] watchdogCount;
  logic [15:0] plainRegs [0:15];
  cmd_reg_pkg::cmd_state_t cmdState;

  // ****************************************************************
  // Decode
  // ****************************************************************
  function automatic logic hit(input logic [5:0] sel, input logic [5:0] ofs);
    hit = (sel == ofs);
  endfunction : hit

  function automatic logic [15:0] tallyStep(input logic [15:0] value, input logic ev);
    tallyStep = ev ? value + 16'h0001 : value;
  endfunction : tallyStep

  wire logic writeAccess = chipSelect && writeStrobe;
  wire logic readAccess = chipSelect && readStrobe;
  wire logic inSoftReset = commandBits[`BIT_SOFT_RESET];
  wire logic cmdWrite = writeAccess && hit(registerSelectLines, `OFS_COMMAND);
  wire logic [15:0] setBits = cmdWrite ? (writeData & `CMD_WRITABLE_MASK) : 16'h0000;
  wire logic cmdAccepted = !inSoftReset;
  wire logic startReq = setBits[`BIT_TIMER_START] && !setBits[`BIT_TIMER_STOP];
  wire logic stopReq = setBits[`BIT_TIMER_STOP];
  wire logic timerRunning = commandBits[`BIT_TIMER_START];
  wire logic timerAtZero = (watchdogCount == 32'h00000000);
  wire logic timerLoading = writeAccess &&
    (hit(registerSelectLines, `OFS_WATCHDOG_LOW) || hit(registerSelectLines, `OFS_WATCHDOG_HIGH));
  // Folds the plain registers onto sixteen slots; the two receive word counts move to free slots.
  wire logic [3:0] plainIndex = hit(registerSelectLines, `OFS_RX_WORDS_LOW) ? 4'hc
    : hit(registerSelectLines, `OFS_RX_WORDS_HIGH) ? 4'hd
    : registerSelectLines[3:0] ^ {registerSelectLines[4], 3'b000};
  wire logic plainHit = hit(registerSelectLines, `OFS_TX_FRAG_COUNT)
    || hit(registerSelectLines, `OFS_TX_START_LOW) || hit(registerSelectLines, `OFS_TX_START_HIGH)
    || hit(registerSelectLines, `OFS_RX_BUF_LOW) || hit(registerSelectLines, `OFS_RX_BUF_HIGH)
    || hit(registerSelectLines, `OFS_RX_WORDS_LOW) || hit(registerSelectLines, `OFS_RX_WORDS_HIGH)
    || hit(registerSelectLines, `OFS_TEMP_RX_LOW) || hit(registerSelectLines, `OFS_TEMP_RX_HIGH)
    || hit(registerSelectLines, `OFS_TEMP_WORDS_LOW) || hit(registerSelectLines, `OFS_TEMP_WORDS_HIGH)
    || hit(registerSelectLines, `OFS_ADDR_GEN_LOW) || hit(registerSelectLines, `OFS_ADDR_GEN_HIGH)
    || hit(registerSelectLines, `OFS_LAST_LINK) || hit(registerSelectLines, `OFS_TEMP_TX_DESC);
  wire logic [15:0] fragShifted = dataConfig[`DCFG_WIDTH_BIT] ? {writeData[13:0], 2'b00}
    : {writeData[14:0], 1'b0};

  // ****************************************************************
  // Command register next value
  // ****************************************************************
  logic [15:0] next_commandBits;
  always_comb
  begin
    next_commandBits = commandBits;
    if (cmdWrite)
    begin
      next_commandBits[`BIT_SOFT_RESET] = writeData[`BIT_SOFT_RESET];
      if (cmdAccepted)
      begin
        next_commandBits = next_commandBits | (setBits & ~16'h0030 & ~16'h0080);
        if (startReq)
        begin
          next_commandBits[`BIT_TIMER_START] = 1'b1;
          next_commandBits[`BIT_TIMER_STOP] = 1'b0;
        end
        if (stopReq)
        begin
          next_commandBits[`BIT_TIMER_STOP] = 1'b1;
          next_commandBits[`BIT_TIMER_START] = 1'b0;
        end
      end
    end
    if (cmdState == cmd_reg_pkg::CMD_LOAD_MATCH && matchLoadDone)
      next_commandBits[`BIT_LOAD_MATCH] = 1'b0;
    if (cmdState == cmd_reg_pkg::CMD_READ_RES && resourceReadDone)
      next_commandBits[`BIT_READ_RES] = 1'b0;
    // Transmit bits and the receive-on bit are serviced by other engines and settle here at once.
    next_commandBits[`BIT_TX_GO] = 1'b0;
    next_commandBits[`BIT_TX_HALT] = 1'b0;
    next_commandBits[`BIT_RX_ON] = 1'b0;
    if (timerRunning && timerAtZero && !startReq)
      next_commandBits[`BIT_TIMER_START] = 1'b0;
    if (cmdWrite && writeData[`BIT_SOFT_RESET] && !inSoftReset)
    begin
      next_commandBits = (next_commandBits & ~`CMD_SW_CLEAR_MASK) | `CMD_SW_SET_MASK;
    end
    next_commandBits[15:10] = 6'h00;
    next_commandBits[6] = 1'b0;
  end

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  cmd_reg_pkg::cmd_state_t next_cmdState;
  always_comb
  begin
    next_cmdState = cmdState;
    case (cmdState)
      cmd_reg_pkg::CMD_IDLE:
      begin
        if (next_commandBits[`BIT_LOAD_MATCH] && !next_commandBits[`BIT_SOFT_RESET])
          next_cmdState = cmd_reg_pkg::CMD_LOAD_MATCH;
        else if (next_commandBits[`BIT_READ_RES] && !next_commandBits[`BIT_SOFT_RESET])
          next_cmdState = cmd_reg_pkg::CMD_READ_RES;
      end
      cmd_reg_pkg::CMD_LOAD_MATCH:
        if (matchLoadDone)
          next_cmdState = cmd_reg_pkg::CMD_IDLE;
      cmd_reg_pkg::CMD_READ_RES:
        if (resourceReadDone)
          next_cmdState = cmd_reg_pkg::CMD_IDLE;
      default:
        next_cmdState = cmd_reg_pkg::CMD_IDLE;
    endcase
    if (next_commandBits[`BIT_SOFT_RESET])
      next_cmdState = cmd_reg_pkg::CMD_IDLE;
  end

  // ****************************************************************
  // Sequential state
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      commandBits <= `CMD_HW_RESET;
      cmdState <= cmd_reg_pkg::CMD_IDLE;
    end
    else if (clkEn)
    begin
      commandBits <= next_commandBits;
      cmdState <= next_cmdState;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dataConfig <= 16'h0000;
      dataConfigTwo <= 16'h0000;
      intMask <= 16'h0000;
      matchEnable <= 16'h0000;
      matchDescPointer <= 16'h0000;
      resourceReadPointer <= 16'h0000;
    end
    else if (clkEn)
    begin
      if (writeAccess && inSoftReset && hit(registerSelectLines, `OFS_DATA_CONFIG))
        dataConfig <= writeData;
      if (writeAccess && inSoftReset && hit(registerSelectLines, `OFS_DATA_CONFIG_TWO))
        dataConfigTwo <= writeData;
      if (writeAccess && hit(registerSelectLines, `OFS_INT_MASK))
        intMask <= writeData;
      if (cmdState == cmd_reg_pkg::CMD_LOAD_MATCH && matchLoadDone)
        matchEnable <= matchEnableLoad;
      else if (writeAccess && inSoftReset && hit(registerSelectLines, `OFS_MATCH_ENABLE))
        matchEnable <= writeData;
      if (writeAccess && hit(registerSelectLines, `OFS_MATCH_DESC_PTR))
        matchDescPointer <= writeData;
      if (writeAccess && hit(registerSelectLines, `OFS_RES_READ_PTR))
        resourceReadPointer <= writeData;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      crcTally <= 16'h0000;
      alignTally <= 16'h0000;
      missedTally <= 16'h0000;
      txPacketSize <= 16'h0000;
      txFragmentSize <= 16'h0000;
    end
    else if (clkEn)
    begin
      if (writeAccess && hit(registerSelectLines, `OFS_CRC_TALLY))
        crcTally <= ~writeData;
      else if (!inSoftReset)
        crcTally <= tallyStep(crcTally, crcErrorEvent);
      if (writeAccess && hit(registerSelectLines, `OFS_ALIGN_TALLY))
        alignTally <= ~writeData;
      else if (!inSoftReset)
        alignTally <= tallyStep(alignTally, alignErrorEvent);
      if (writeAccess && hit(registerSelectLines, `OFS_MISSED_TALLY))
        missedTally <= ~writeData;
      else if (!inSoftReset)
        missedTally <= tallyStep(missedTally, missedPacketEvent);
      if (writeAccess && hit(registerSelectLines, `OFS_TX_PACKET_SIZE))
        txPacketSize <= writeData;
      if (writeAccess && hit(registerSelectLines, `OFS_TX_FRAG_SIZE))
        txFragmentSize <= fragShifted;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      watchdogCount <= 32'h00000000;
      for (int i = 0; i < 16; i++)
        plainRegs[i] <= 16'h0000;
    end
    else if (clkEn)
    begin
      if (writeAccess && hit(registerSelectLines, `OFS_WATCHDOG_LOW))
        watchdogCount[15:0] <= writeData;
      else if (writeAccess && hit(registerSelectLines, `OFS_WATCHDOG_HIGH))
        watchdogCount[31:16] <= writeData;
      else if (timerRunning && !timerAtZero)
        watchdogCount <= watchdogCount - 32'h00000001;
      if (writeAccess && plainHit)
        plainRegs[plainIndex] <= writeData;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [15:0] next_readData;
  always_comb
  begin
    next_readData = 16'h0000;
    if (hit(registerSelectLines, `OFS_COMMAND))
      next_readData = commandBits;
    else if (hit(registerSelectLines, `OFS_DATA_CONFIG))
      next_readData = dataConfig;
    else if (hit(registerSelectLines, `OFS_DATA_CONFIG_TWO))
      next_readData = dataConfigTwo;
    else if (hit(registerSelectLines, `OFS_INT_MASK))
      next_readData = intMask;
    else if (hit(registerSelectLines, `OFS_MATCH_ENABLE))
      next_readData = matchEnable;
    else if (hit(registerSelectLines, `OFS_MATCH_DESC_PTR))
      next_readData = matchDescPointer;
    else if (hit(registerSelectLines, `OFS_RES_READ_PTR))
      next_readData = resourceReadPointer;
    else if (hit(registerSelectLines, `OFS_MATCH_PORT_ZERO))
      next_readData = inSoftReset ? matchEntryData[15:0] : 16'h0000;
    else if (hit(registerSelectLines, `OFS_MATCH_PORT_ONE))
      next_readData = inSoftReset ? matchEntryData[31:16] : 16'h0000;
    else if (hit(registerSelectLines, `OFS_MATCH_PORT_TWO))
      next_readData = inSoftReset ? matchEntryData[47:32] : 16'h0000;
    else if (hit(registerSelectLines, `OFS_CRC_TALLY))
      next_readData = crcTally;
    else if (hit(registerSelectLines, `OFS_ALIGN_TALLY))
      next_readData = alignTally;
    else if (hit(registerSelectLines, `OFS_MISSED_TALLY))
      next_readData = missedTally;
    else if (hit(registerSelectLines, `OFS_TX_PACKET_SIZE))
      next_readData = ~txPacketSize;
    else if (hit(registerSelectLines, `OFS_TX_FRAG_SIZE))
      next_readData = txFragmentSize;
    else if (hit(registerSelectLines, `OFS_WATCHDOG_LOW))
      next_readData = watchdogCount[15:0];
    else if (hit(registerSelectLines, `OFS_WATCHDOG_HIGH))
      next_readData = watchdogCount[31:16];
    else if (hit(registerSelectLines, `OFS_SILICON_REV))
      next_readData = `SILICON_REV_VALUE;
    else if (plainHit)
      next_readData = plainRegs[plainIndex];
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      readData <= 16'h0000;
      loadMatchRequest <= 1'b0;
      readResourceRequest <= 1'b0;
      descPointer <= 16'h0000;
      enginesHeld <= 1'b1;
      timerInterrupt <= 1'b0;
    end
    else if (clkEn)
    begin
      if (readAccess)
        readData <= next_readData;
      loadMatchRequest <= (next_cmdState == cmd_reg_pkg::CMD_LOAD_MATCH);
      readResourceRequest <= (next_cmdState == cmd_reg_pkg::CMD_READ_RES);
      descPointer <= (next_cmdState == cmd_reg_pkg::CMD_READ_RES) ? resourceReadPointer : matchDescPointer;
      enginesHeld <= next_commandBits[`BIT_SOFT_RESET];
      timerInterrupt <= timerRunning && !timerLoading && (watchdogCount == 32'h00000001)
        && intMask[`INT_MASK_TIMER_BIT];
    end
  end

endmodule : command_register_control
`default_nettype wire

//--- dv/command_register_control_asserts.sv
// Port-level checker for the command register block, with its bind.
`timescale 1ns/1ps
`default_nettype none
`include "cmd_reg_defines.svh"
module command_register_control_asserts (
  // Clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Host register port
  input wire logic chipSelect,
  input wire logic writeStrobe,
  input wire logic [5:0] registerSelectLines,
  input wire logic [15:0] writeData,
  // Engine handshake
  input wire logic matchLoadDone,
  input wire logic resourceReadDone,
  input wire logic loadMatchRequest,
  input wire logic readResourceRequest,
  input wire logic enginesHeld,
  input wire logic timerInterrupt
);
  // ****************************************
  // Command write decode and properties.
  // ****************************************
  wire wrCmd = clkEn && chipSelect && writeStrobe && (registerSelectLines == `OFS_COMMAND);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  AST_RESET_STATE: assert property ($fell(sys_rst) |-> enginesHeld && !loadMatchRequest && !timerInterrupt)
    else $error("state after reset wrong");
  AST_NO_CMD_IN_RESET: assert property (wrCmd && enginesHeld |=> !loadMatchRequest && !readResourceRequest)
    else $error("command accepted in reset");
  AST_SOFT_RESET: assert property (wrCmd && writeData[`BIT_SOFT_RESET] |=> enginesHeld && !loadMatchRequest)
    else $error("soft reset did not take");
  AST_LOAD_DONE: assert property (clkEn && loadMatchRequest && matchLoadDone |=> !loadMatchRequest)
    else $error("load request not cleared");
  AST_FETCH_DONE: assert property (clkEn && readResourceRequest && resourceReadDone |=> !readResourceRequest)
    else $error("fetch request not cleared");
  AST_ZERO_KEEPS: assert property (clkEn && loadMatchRequest && !matchLoadDone
    && !(wrCmd && writeData[`BIT_SOFT_RESET]) |=> loadMatchRequest)
    else $error("load request dropped early");
  AST_LOAD_START: assert property (wrCmd && !enginesHeld && !loadMatchRequest && !readResourceRequest
    && writeData[`BIT_LOAD_MATCH]
    && !writeData[`BIT_SOFT_RESET] |=> loadMatchRequest)
    else $error("load command not started");
  AST_HELD_CAUSE: assert property ($changed(enginesHeld) |-> $past(wrCmd))
    else $error("held state changed without write");
  AST_NOT_WHILE_HELD: assert property (enginesHeld |-> !loadMatchRequest && !readResourceRequest)
    else $error("request while held");
  AST_IRQ_PULSE: assert property (clkEn && timerInterrupt |=> !timerInterrupt)
    else $error("interrupt longer than one cycle");
  cover property (loadMatchRequest && matchLoadDone);
  cover property (readResourceRequest && resourceReadDone);
  cover property (timerInterrupt);
endmodule : command_register_control_asserts
bind command_register_control command_register_control_asserts u_chk (.clk(clk), .sys_rst(sys_rst),
  .clkEn(clkEn), .chipSelect(chipSelect), .writeStrobe(writeStrobe), .registerSelectLines(registerSelectLines),
  .writeData(writeData), .matchLoadDone(matchLoadDone), .resourceReadDone(resourceReadDone),
  .loadMatchRequest(loadMatchRequest), .readResourceRequest(readResourceRequest),
  .enginesHeld(enginesHeld), .timerInterrupt(timerInterrupt));
`default_nettype wire

//--- dv/command_register_control_tb_top.sv
// Self-checking testbench for the command register block.
`timescale 1ns/1ps
`default_nettype none
module command_register_control_tb_top;
  logic clk, sys_rst, ce, cs, ws, rs;
  logic [5:0] sel;
  logic [15:0] wd, rv;
  logic [4:0] ev;
  logic seen;
  wire logic [15:0] readData, descPointer;
  wire logic loadReq, fetchReq, enginesHeld, timerInterrupt;
  int failures, tests_run;
  command_register_control dut (.clk(clk), .sys_rst(sys_rst), .clkEn(ce), .chipSelect(cs), .writeStrobe(ws),
    .readStrobe(rs), .registerSelectLines(sel), .writeData(wd), .readData(readData), .matchLoadDone(ev[0]),
    .resourceReadDone(ev[1]), .matchEnableLoad(16'h00f0), .matchEntryData(48'h3333_2222_1111),
    .crcErrorEvent(ev[2]), .alignErrorEvent(ev[3]), .missedPacketEvent(ev[4]), .loadMatchRequest(loadReq),
    .readResourceRequest(fetchReq), .descPointer(descPointer), .enginesHeld(enginesHeld),
    .timerInterrupt(timerInterrupt));
  // ****************************************
  // Bus cycles and comparisons.
  // ****************************************
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t value got %h expected %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chkBit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask : chkBit
  task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d);
    chkBit(a < 6'h30 || a > 6'h3e, 1'b1);
    @(posedge clk);
    cs <= 1'b1;
    ws <= w;
    rs <= !w;
    sel <= a;
    wd <= d;
    @(posedge clk);
    cs <= 1'b0;
    ws <= 1'b0;
    rs <= 1'b0;
    #1;
    rv = readData;
  endtask : acc
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    acc(1'b1, a, d);
  endtask : wr
  task automatic rdChk(input logic [5:0] a, input logic [15:0] exp);
    acc(1'b0, a, 16'h0000);
    chk16(rv, exp);
  endtask : rdChk
  task automatic pulse(input int i, input int n);
    @(posedge clk);
    ev[i] <= 1'b1;
    repeat (n) @(posedge clk);
    ev[i] <= 1'b0;
    #1;
  endtask : pulse
  task automatic waitIrq();
    seen = 1'b0;
    repeat (20)
    begin
      @(posedge clk);
      #1;
      if (timerInterrupt === 1'b1) seen = 1'b1;
    end
  endtask : waitIrq
  task automatic hwReset();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    rdChk(6'h00, 16'h0094);
    chkBit(enginesHeld, 1'b1);
  endtask : hwReset
  // ****************************************
  // Scenarios.
  // ****************************************
  task automatic testResetMode();
    rdChk(6'h28, 16'h0001);
    wr(6'h28, 16'hffff);
    rdChk(6'h28, 16'h0001);
    rdChk(6'h02, 16'h0000);
    wr(6'h01, 16'h0000);
    wr(6'h0c, 16'h0101);
    rdChk(6'h0c, 16'h0202);
    wr(6'h01, 16'h0020);
    wr(6'h0c, 16'h0101);
    rdChk(6'h0c, 16'h0404);
    wr(6'h3f, 16'h0003);
    wr(6'h25, 16'h00a5);
    rdChk(6'h24, 16'h1111);
    rdChk(6'h23, 16'h2222);
    rdChk(6'h22, 16'h3333);
    wr(6'h00, 16'h0000);
    rdChk(6'h00, 16'h0014);
    chkBit(enginesHeld, 1'b0);
    wr(6'h01, 16'h0000);
    wr(6'h3f, 16'h0000);
    wr(6'h25, 16'h0000);
    rdChk(6'h01, 16'h0020);
    rdChk(6'h3f, 16'h0003);
    rdChk(6'h25, 16'h00a5);
    rdChk(6'h24, 16'h0000);
    wr(6'h08, 16'h1234);
    rdChk(6'h08, 16'hedcb);
  endtask : testResetMode
  task automatic testTallies();
    for (int i = 0; i < 3; i++)
    begin
      wr(6'(i + 32'h2c), 16'hffff);
      rdChk(6'(i + 32'h2c), 16'h0000);
      pulse(2 + i, 3);
      rdChk(6'(i + 32'h2c), 16'h0003);
    end
    wr(6'h00, 16'h0080);
    rdChk(6'h00, 16'h0094);
    for (int i = 0; i < 3; i++)
    begin
      pulse(2 + i, 2);
      rdChk(6'(i + 32'h2c), 16'h0003);
    end
    wr(6'h00, 16'h0200);
    chkBit(loadReq, 1'b0);
    rdChk(6'h00, 16'h0014);
  endtask : testTallies
  task automatic testCommands();
    wr(6'h26, 16'h1230);
    wr(6'h00, 16'h0200);
    chkBit(loadReq, 1'b1);
    chk16(descPointer, 16'h1230);
    wr(6'h00, 16'h0000);
    chkBit(loadReq, 1'b1);
    rdChk(6'h00, 16'h0214);
    pulse(0, 1);
    chkBit(loadReq, 1'b0);
    rdChk(6'h00, 16'h0014);
    rdChk(6'h25, 16'h00f0);
    wr(6'h00, 16'h0200);
    wr(6'h00, 16'h0080);
    chkBit(loadReq, 1'b0);
    rdChk(6'h00, 16'h0094);
    wr(6'h00, 16'h0000);
    wr(6'h17, 16'h0456);
    wr(6'h00, 16'h0100);
    chkBit(fetchReq, 1'b1);
    chk16(descPointer, 16'h0456);
    pulse(1, 1);
    chkBit(fetchReq, 1'b0);
    rdChk(6'h00, 16'h0014);
  endtask : testCommands
  task automatic testTimer();
    wr(6'h29, 16'h1234);
    wr(6'h2a, 16'h0005);
    rdChk(6'h29, 16'h1234);
    rdChk(6'h2a, 16'h0005);
    wr(6'h00, 16'h0030);
    rdChk(6'h00, 16'h0014);
    rdChk(6'h29, 16'h1234);
    wr(6'h00, 16'h0020);
    rdChk(6'h00, 16'h0024);
    wr(6'h00, 16'h0010);
    rdChk(6'h00, 16'h0014);
    rdChk(6'h29, 16'h1230);
    rdChk(6'h29, 16'h1230);
    rdChk(6'h2a, 16'h0005);
    wr(6'h04, 16'h0001);
    wr(6'h29, 16'h0004);
    wr(6'h2a, 16'h0000);
    wr(6'h00, 16'h0020);
    waitIrq();
    chkBit(seen, 1'b1);
    rdChk(6'h00, 16'h0004);
    wr(6'h04, 16'h0000);
    wr(6'h29, 16'h0004);
    wr(6'h00, 16'h0020);
    waitIrq();
    chkBit(seen, 1'b0);
  endtask : testTimer
  task automatic testFreeze();
    @(posedge clk);
    ce <= 1'b0;
    wr(6'h29, 16'h0077);
    @(posedge clk);
    ce <= 1'b1;
    rdChk(6'h29, 16'h0000);
    rdChk(6'h00, 16'h0004);
  endtask : testFreeze
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  initial
  begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  initial
  begin
    #500000;
    failures++;
    conclude();
  end
  initial
  begin
    {cs, ws, rs, sel, wd, ev} = '0;
    sys_rst = 1'b1;
    ce = 1'b1;
    failures = 0;
    tests_run = 0;
    hwReset();
    testResetMode();
    testTallies();
    testCommands();
    testTimer();
    testFreeze();
    hwReset();
    conclude();
  end
endmodule : command_register_control_tb_top
`default_nettype wire
